// file: logic/slc_top.sv
// Summary of operation
// RULE1 - signaller contact switches around setpoint with symmetric differential
// RULE2 - second signaller contact sits at setpoint plus signed offset
// RULE3 - extra contact offset is signed and resets to zero
// RULE4 - control word selects mode and direct or inverse action
// RULE5 - two-point mode turns correcting variable into on/off duty cycle
// RULE6 - cycle time gives switching period, default five seconds
// RULE7 - no on or off pulse shorter than about 63 ms
// RULE8 - zero error gives working point as output
// RULE9 - zero integral time disables integral accumulation
// RULE10 - two-point limits and working point default 0, 100, 0 percent
// RULE11 - three-point output spans full heat to full cool
// RULE12 - direct action in three-point mode only swaps the outputs
// RULE13 - separate heat and cool neutral zones, default zero
// RULE14 - inside neutral zone correcting variable is held
// RULE15 - heat and cool channels have own cycle times
// RULE16 - water cooling turns cool cycle time into minimum off pulse
// RULE17 - three-point limits -100 and 100, high above low
// RULE18 - separate band, integral and derivative for heat and cool
// RULE19 - tuning comes from one of two parameter sets, functions 6, 7
// RULE20 - nonzero integral time integrates error to remove offset
// RULE21 - parameter set chosen by software bit or by pin
// RULE22 - correcting variable clipped to limits before duty conversion
// RULE23 - proportional term is error times 100 over band plus working point
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module slc_top #(
  parameter int unsigned MS_CYCLES = slc_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic param_set_pin_i,
  output logic out1_o,
  output logic out2_o
);
  import slc_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic signed [31:0] sx(input logic [15:0] v);
    sx = {{16{v[15]}}, v};
  endfunction : sx

  function automatic logic signed [31:0] clip(input logic signed [31:0] v,
    input logic signed [31:0] lo, input logic signed [31:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clip

  function automatic logic [31:0] eff_on(input logic [31:0] on,
    input logic [31:0] per, input logic [31:0] mon, input logic [31:0] moff);
    if (on < mon)
      eff_on = 32'h0;
    else if (on >= per || (per - on) < moff)
      eff_on = per;
    else
      eff_on = on;
  endfunction : eff_on

  function automatic logic [15:0] wmerge(input logic [15:0] old,
    input logic [31:0] d, input logic [3:0] sel);
    wmerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : wmerge

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic [15:0] cfg_r [CFG_WORDS];
  logic [15:0] pset_r [2*PSET_WORDS];
  logic ack_r;
  logic [31:0] rdat_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic act_set_r;
  logic req;
  logic wr;
  logic [3:0] ci;
  logic [3:0] pi;
  logic [15:0] wv;
  logic signed [31:0] y_r;
  logic out1_r;
  logic out2_r;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i;
  assign ci = wb_adr_i[5:2];
  assign pi = wb_adr_i[5:2];
  assign wv = wmerge(cfg_r[ci], wb_dat_i, wb_sel_i);

  // config writes with their side effects
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (int k = 0; k < CFG_WORDS; k++)
        cfg_r[k] <= 16'h0000;
      cfg_r[CFG_CTRL] <= {14'h0000, MODE_TWO};
      cfg_r[CFG_SD] <= RST_SD; // RULE1
      cfg_r[CFG_XOFF] <= RST_XOFF; // RULE3
      cfg_r[CFG_XSD] <= RST_SD;
      cfg_r[CFG_YLO] <= RST_YLO_2P; // RULE10
      cfg_r[CFG_YHI] <= RST_YHI;
      cfg_r[CFG_Y0] <= RST_Y0;
    end
    else if (ce_i && wr && wb_adr_i[7:6] == 2'b00)
    begin
      if (ci == CFG_CTRL)
      begin
        cfg_r[ci] <= wv; // RULE4
        if (wv[1:0] != cfg_r[CFG_CTRL][1:0])
        begin
          cfg_r[CFG_YLO] <= (wv[1:0] == MODE_THREE) ? RST_YLO_3P
                            : RST_YLO_2P; // RULE17
          cfg_r[CFG_YHI] <= RST_YHI;
          cfg_r[CFG_Y0] <= RST_Y0;
        end
      end
      else if (ci == CFG_YHI)
      begin
        if (sx(wv) > sx(cfg_r[CFG_YLO]))
          cfg_r[ci] <= wv; // RULE17
      end
      else if (ci == CFG_YLO)
      begin
        if (sx(wv) < sx(cfg_r[CFG_YHI]))
          cfg_r[ci] <= wv;
      end
      else
        cfg_r[ci] <= wv;
    end
  end

  // two parameter sets
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (int s = 0; s < 2; s++)
      begin
        pset_r[s*8+PS_XPH] <= RST_XP;
        pset_r[s*8+PS_XPC] <= RST_XP;
        pset_r[s*8+PS_TIH] <= RST_TI;
        pset_r[s*8+PS_TIC] <= RST_TI;
        pset_r[s*8+PS_TDH] <= RST_TD;
        pset_r[s*8+PS_TDC] <= RST_TD;
        pset_r[s*8+PS_CYH] <= RST_CY; // RULE6
        pset_r[s*8+PS_CYC] <= RST_CY; // RULE15
      end
    end
    else if (ce_i && wr && wb_adr_i[7:6] == 2'b01)
      pset_r[pi] <= wmerge(pset_r[pi], wb_dat_i, wb_sel_i); // RULE19
  end

  // bus answer, one cycle after request
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else if (ce_i)
    begin
      ack_r <= req;
      rdat_r <= 32'h00000000;
      if (req && !wb_we_i)
      begin
        if (wb_adr_i[7:6] == 2'b00)
          rdat_r <= {16'h0000, cfg_r[ci]};
        else if (wb_adr_i[7:6] == 2'b01)
          rdat_r <= {16'h0000, pset_r[pi]};
        else if (wb_adr_i == ADR_STATUS)
          rdat_r <= {13'h0000, act_set_r, out2_r, out1_r, y_r[15:0]};
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // set select pin sync and source choice
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      act_set_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_s1_r <= param_set_pin_i;
      pin_s2_r <= pin_s1_r;
      act_set_r <= cfg_r[CFG_CTRL][CTRL_SET_PIN] ? pin_s2_r
                   : cfg_r[CFG_CTRL][CTRL_SET_SW]; // RULE21
    end
  end

  // ---------------------------------------------------------------
  // timebase: ms tick and control step tick
  // ---------------------------------------------------------------
  logic [31:0] ms_cnt_r;
  logic ms_tick_r;
  logic [7:0] step_cnt_r;
  logic step_tick_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ms_cnt_r <= 32'h0;
      ms_tick_r <= 1'b0;
      step_cnt_r <= 8'h00;
      step_tick_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ms_tick_r <= (ms_cnt_r == 32'(MS_CYCLES - 1));
      ms_cnt_r <= (ms_cnt_r == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt_r + 32'h1;
      step_tick_r <= 1'b0;
      if (ms_tick_r)
      begin
        step_tick_r <= (step_cnt_r == 8'(STEP_MS - 1));
        step_cnt_r <= (step_cnt_r == 8'(STEP_MS - 1)) ? 8'h00
                      : step_cnt_r + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // control law
  // ---------------------------------------------------------------
  slc_div_if dv ();
  slc_div u_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .dv(dv.slave)
  );

  slc_mode_e mode;
  logic direct;
  logic signed [31:0] x;
  logic signed [31:0] w;
  logic signed [31:0] err;
  logic heat_side;
  logic in_zone;
  logic [15:0] xp;
  logic [15:0] ti;
  logic [15:0] td;
  logic signed [31:0] ylo;
  logic signed [31:0] yhi;
  logic [3:0] sb;
  slc_state_e st_r;
  logic signed [31:0] p_r;
  logic signed [31:0] p_prev_r;
  logic signed [31:0] integ_r;
  logic [31:0] on_heat_r;
  logic [31:0] on_cool_r;
  logic start_r;
  logic [31:0] dvd_r;
  logic [15:0] dvs_r;
  logic signed [47:0] dprod;
  logic signed [31:0] ysum;

  assign mode = slc_mode_e'(cfg_r[CFG_CTRL][1:0]);
  assign direct = cfg_r[CFG_CTRL][CTRL_DIRECT];
  assign x = sx(cfg_r[CFG_PV]);
  assign w = sx(cfg_r[CFG_SP]);
  // direct action flips error except in three-point mode
  assign err = (direct && mode != MODE_THREE) ? x - w : w - x; // RULE12
  assign heat_side = (err >= 0) || (mode != MODE_THREE);
  assign sb = {act_set_r, 3'h0};
  assign xp = pset_r[sb | (heat_side ? PS_XPH : PS_XPC)]; // RULE18
  assign ti = pset_r[sb | (heat_side ? PS_TIH : PS_TIC)];
  assign td = pset_r[sb | (heat_side ? PS_TDH : PS_TDC)];
  assign ylo = sx(cfg_r[CFG_YLO]);
  assign yhi = sx(cfg_r[CFG_YHI]);
  assign in_zone = (err < sx(cfg_r[CFG_NZH]))
                   && (-err < sx(cfg_r[CFG_NZC])); // RULE13
  assign dprod = 48'(p_r - p_prev_r) * $signed({32'h0, td})
                 * 48'sd10;
  assign ysum = clip(sx(cfg_r[CFG_Y0]), ylo, yhi) + p_r + integ_r
                + clip(32'(dprod), -P_SAT, P_SAT);
  assign dv.start = start_r;
  assign dv.dividend = dvd_r;
  assign dv.divisor = dvs_r;

  // step sequencer: band divide, integral divide, sum, duty divide
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_IDLE;
      p_r <= 32'sd0;
      p_prev_r <= 32'sd0;
      integ_r <= 32'sd0;
      y_r <= 32'sd0;
      on_heat_r <= 32'h0;
      on_cool_r <= 32'h0;
      start_r <= 1'b0;
      dvd_r <= 32'h0;
      dvs_r <= 16'h0001;
    end
    else if (ce_i)
    begin
      start_r <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          // in three-point mode nothing is recomputed inside the zone
          if (step_tick_r && mode[1] && !(mode == MODE_THREE && in_zone))
          begin // RULE14
            dvd_r <= 32'(err < 0 ? -err : err) * PCT_SCALE;
            dvs_r <= (xp == 16'h0) ? 16'h0001 : xp;
            start_r <= 1'b1;
            st_r <= ST_PDIV;
          end
        end
        ST_PDIV:
          if (dv.done)
          begin
            p_r <= clip(err < 0 ? -$signed(dv.quotient)
                        : $signed(dv.quotient), -P_SAT, P_SAT); // RULE23
            if (ti == 16'h0)
            begin
              integ_r <= 32'sd0; // RULE9
              st_r <= ST_SUM;
            end
            else
            begin
              dvd_r <= dv.quotient;
              dvs_r <= 16'(ti * TENTHS);
              start_r <= 1'b1;
              st_r <= ST_IDIV;
            end
          end
        ST_IDIV:
          if (dv.done)
          begin
            integ_r <= clip(integ_r + (p_r < 0 ? -$signed(dv.quotient)
                            : $signed(dv.quotient)), -Y_FULL, Y_FULL); // RULE20
            st_r <= ST_SUM;
          end
        ST_SUM:
        begin
          y_r <= clip(ysum, ylo, yhi); // RULE8 RULE22
          p_prev_r <= p_r;
          dvd_r <= 32'(clip(ysum, ylo, yhi) < 0 ? -clip(ysum, ylo, yhi)
                   : clip(ysum, ylo, yhi)) * 32'(pset_r[sb |
                   (clip(ysum, ylo, yhi) < 0 ? PS_CYC : PS_CYH)]);
          dvs_r <= TENTHS;
          start_r <= 1'b1;
          st_r <= ST_ODIV;
        end
        ST_ODIV:
          if (dv.done)
          begin
            // positive drives heating, negative cooling in three-point mode only
            on_heat_r <= (y_r > 0) ? dv.quotient : 32'h0; // RULE11
            on_cool_r <= (y_r < 0 && mode == MODE_THREE) ? dv.quotient
                         : 32'h0;
            st_r <= ST_IDLE;
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // duty cycle outputs, counted in ms
  // ---------------------------------------------------------------
  logic [31:0] pw_cnt_r [2];
  logic [31:0] pw_per_r [2];
  logic [31:0] pw_on_r [2];
  logic [31:0] per_new [2];
  logic [31:0] moff [2];
  logic water;

  assign water = cfg_r[CFG_CTRL][CTRL_WATER];
  assign per_new[0] = 32'(pset_r[sb | PS_CYH]) * MS_PER_TENTH_S; // RULE6
  assign per_new[1] = water ? per_new[0]
                      : 32'(pset_r[sb | PS_CYC]) * MS_PER_TENTH_S;
  assign moff[0] = MIN_PULSE_MS;
  assign moff[1] = water ? 32'(pset_r[sb | PS_CYC]) * MS_PER_TENTH_S
                   : MIN_PULSE_MS; // RULE16

  // new on-time and period taken only at period wrap
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        pw_cnt_r[c] <= 32'h0;
        pw_per_r[c] <= 32'h0;
        pw_on_r[c] <= 32'h0;
      end
    end
    else if (ce_i && ms_tick_r)
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (pw_cnt_r[c] + 32'h1 >= pw_per_r[c])
        begin
          pw_cnt_r[c] <= 32'h0;
          pw_per_r[c] <= per_new[c];
          pw_on_r[c] <= eff_on(c == 0 ? on_heat_r : on_cool_r, per_new[c],
                               MIN_PULSE_MS, moff[c]); // RULE7
        end
        else
          pw_cnt_r[c] <= pw_cnt_r[c] + 32'h1;
      end
    end
  end

  // signaller contacts with hysteresis, then output routing
  logic sig1_r;
  logic sig2_r;
  logic signed [31:0] hsd1;
  logic signed [31:0] hsd2;
  logic signed [31:0] w2;
  logic pwh;
  logic pwc;

  assign hsd1 = sx(cfg_r[CFG_SD]) >>> 1;
  assign hsd2 = sx(cfg_r[CFG_XSD]) >>> 1;
  assign w2 = w + sx(cfg_r[CFG_XOFF]);
  assign pwh = pw_cnt_r[0] < pw_on_r[0];
  assign pwc = pw_cnt_r[1] < pw_on_r[1];

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      sig1_r <= 1'b0;
      sig2_r <= 1'b0;
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (x < w - hsd1)
        sig1_r <= !direct; // RULE1
      else if (x > w + hsd1)
        sig1_r <= direct;
      if (x < w2 - hsd2)
        sig2_r <= !direct; // RULE2
      else if (x > w2 + hsd2)
        sig2_r <= direct;
      case (mode)
        MODE_SIG1:
        begin
          out1_r <= sig1_r;
          out2_r <= 1'b0;
        end
        MODE_SIG2:
        begin
          out1_r <= sig1_r;
          out2_r <= sig2_r;
        end
        MODE_TWO:
        begin
          out1_r <= pwh; // RULE5
          out2_r <= 1'b0;
        end
        MODE_THREE:
        begin
          out1_r <= direct ? pwc : pwh; // RULE12
          out2_r <= direct ? pwh : pwc;
        end
        default:
        begin
          out1_r <= 1'b0;
          out2_r <= 1'b0;
        end
      endcase
    end
  end
  assign out1_o = out1_r;
  assign out2_o = out2_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [31:0] run_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || !out1_r)
      run_r <= 32'h0;
    else if (ce_i && ms_tick_r)
      run_r <= run_r + 32'h1;
  end

  a_ack_single: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ack_r |=> !ack_r) else $error("ack held two cycles");
  a_ack_after_req: assert property (@(posedge ref_clk_i)
    disable iff (rst_i || !ce_i) req |=> ack_r) else $error("no ack");
  a_min_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mode == MODE_TWO && out1_r && $past(mode) == MODE_TWO) ##1 !out1_r
    |-> $past(run_r) >= MIN_PULSE_MS) else $error("on pulse too short"); // RULE7
  a_y_clipped: assert property (@(posedge ref_clk_i)
    disable iff (rst_i || !ce_i) st_r == ST_SUM |=> y_r >= $past(ylo)
    && y_r <= $past(yhi)) else $error("y outside limits"); // RULE22
  a_zone_hold: assert property (@(posedge ref_clk_i)
    disable iff (rst_i || !ce_i) (st_r == ST_IDLE && step_tick_r
    && mode == MODE_THREE && in_zone) |=> st_r == ST_IDLE && $stable(y_r))
    else $error("y changed in neutral zone"); // RULE14
  a_sig_low_on: assert property (@(posedge ref_clk_i)
    disable iff (rst_i || !ce_i) (mode == MODE_SIG1 && !direct
    && x < w - hsd1) ##1 !mode[1] |=> out1_r)
    else $error("contact not on"); // RULE1
  a_extra_high_off: assert property (@(posedge ref_clk_i)
    disable iff (rst_i || !ce_i) (mode == MODE_SIG2 && !direct
    && x > w2 + hsd2) ##1 mode != MODE_THREE |=> !out2_r)
    else $error("extra contact on"); // RULE2
  a_set_from_pin: assert property (@(posedge ref_clk_i)
    disable iff (rst_i || !ce_i) cfg_r[CFG_CTRL][CTRL_SET_PIN]
    |=> act_set_r == $past(pin_s2_r)) else $error("set select wrong"); // RULE21
  a_no_integral: assert property (@(posedge ref_clk_i)
    disable iff (rst_i || !ce_i) (st_r == ST_PDIV && dv.done && ti == 16'h0)
    |=> integ_r == 32'sd0 && st_r == ST_SUM)
    else $error("integral active at zero time"); // RULE9
endmodule : slc_top
`default_nettype wire

// file: logic/slc_pkg.sv
`default_nettype none
package slc_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MS_PS = 1000000000;
  localparam int unsigned MS_CYCLES_DEF = MS_PS / CLK_PERIOD_PS;
  localparam int unsigned STEP_MS = 100; // control step period
  localparam logic [31:0] MIN_PULSE_MS = 32'd63;
  localparam logic [31:0] MS_PER_TENTH_S = 32'd100;
  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_PSET_A = 8'h40; // parameter set of function 6
  localparam logic [7:0] ADR_PSET_B = 8'h60; // parameter set of function 7
  localparam logic [7:0] ADR_STATUS = 8'h80;
  localparam int unsigned PSET_FUNC_A = 6;
  localparam int unsigned PSET_FUNC_B = 7;
  localparam int unsigned CFG_WORDS = 16;
  localparam int unsigned PSET_WORDS = 8;
  // config word indices
  localparam logic [3:0] CFG_CTRL = 4'h0;
  localparam logic [3:0] CFG_PV = 4'h1;
  localparam logic [3:0] CFG_SP = 4'h2;
  localparam logic [3:0] CFG_SD = 4'h3;
  localparam logic [3:0] CFG_XOFF = 4'h4;
  localparam logic [3:0] CFG_XSD = 4'h5;
  localparam logic [3:0] CFG_YLO = 4'h6;
  localparam logic [3:0] CFG_YHI = 4'h7;
  localparam logic [3:0] CFG_Y0 = 4'h8;
  localparam logic [3:0] CFG_NZH = 4'h9;
  localparam logic [3:0] CFG_NZC = 4'ha;
  // parameter set word indices
  localparam logic [2:0] PS_XPH = 3'h0;
  localparam logic [2:0] PS_XPC = 3'h1;
  localparam logic [2:0] PS_TIH = 3'h2;
  localparam logic [2:0] PS_TIC = 3'h3;
  localparam logic [2:0] PS_TDH = 3'h4;
  localparam logic [2:0] PS_TDC = 3'h5;
  localparam logic [2:0] PS_CYH = 3'h6;
  localparam logic [2:0] PS_CYC = 3'h7;
  // control word fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_DIRECT = 2;
  localparam int unsigned CTRL_SET_SW = 3;
  localparam int unsigned CTRL_SET_PIN = 4;
  localparam int unsigned CTRL_WATER = 5;
  // ---------------------------------------------------------------
  // reset values, tenths of a unit, integral and derivative times in whole seconds
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_SD = 16'h000a; // 1.0
  localparam logic [15:0] RST_XOFF = 16'h0000;
  localparam logic [15:0] RST_XP = 16'h03e8; // 100.0 %
  localparam logic [15:0] RST_TI = 16'h000a; // 10 s
  localparam logic [15:0] RST_TD = 16'h000a; // 10 s
  localparam logic [15:0] RST_CY = 16'h0032; // 5.0 s
  localparam logic [15:0] RST_YLO_2P = 16'h0000; // 0 %
  localparam logic [15:0] RST_YLO_3P = 16'hfc18; // -100 %
  localparam logic [15:0] RST_YHI = 16'h03e8; // 100 %
  localparam logic [15:0] RST_Y0 = 16'h0000;
  localparam logic signed [31:0] Y_FULL = 32'sd1000;
  localparam logic signed [31:0] P_SAT = 32'sd2000;
  localparam logic [31:0] PCT_SCALE = 32'd1000;
  localparam logic [15:0] TENTHS = 16'h000a;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SIG1 = 2'b00,
    MODE_SIG2 = 2'b01,
    MODE_TWO = 2'b10,
    MODE_THREE = 2'b11
  } slc_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PDIV = 3'b001,
    ST_IDIV = 3'b010,
    ST_SUM = 3'b011,
    ST_ODIV = 3'b100
  } slc_state_e;
endpackage : slc_pkg
`default_nettype wire

// file: logic/slc_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface slc_div_if;
  logic start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic done;
  logic [31:0] quotient;
  modport master (output start, output dividend, output divisor,
                  input done, input quotient);
  modport slave (input start, input dividend, input divisor,
                 output done, output quotient);
endinterface : slc_div_if
`default_nettype wire

// file: logic/slc_div.sv
`timescale 1ns/1ps
`default_nettype none
module slc_div (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  slc_div_if.slave dv
);
  import slc_pkg::*;
  logic [16:0] rem_r;
  logic [31:0] quo_r;
  logic [5:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [17:0] sh;
  logic [17:0] dif;

  // one restoring step per clock
  assign sh = {rem_r, quo_r[31]};
  assign dif = sh - {2'b00, dv.divisor};
  assign dv.done = done_r;
  assign dv.quotient = quo_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rem_r <= 17'h00000;
      quo_r <= 32'h00000000;
      cnt_r <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (ce_i)
    begin
      done_r <= 1'b0;
      if (dv.start && !busy_r)
      begin
        rem_r <= 17'h00000;
        quo_r <= dv.dividend;
        cnt_r <= 6'h20;
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        rem_r <= dif[17] ? sh[16:0] : dif[16:0];
        quo_r <= {quo_r[30:0], ~dif[17]};
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule : slc_div
`default_nettype wire

// file: tb/slc_relay_model.sv
`timescale 1ns/1ps
`default_nettype none
module slc_relay_model (
  input wire logic ref_clk_i,
  input wire logic heat_i,
  input wire logic cool_i,
  output logic [31:0] on_o,
  output logic [31:0] cool_on_o
);
  // energised time of each relay, in clock cycles
  initial on_o = 32'h0;
  initial cool_on_o = 32'h0;
  always @(posedge ref_clk_i)
  begin
    if (heat_i === 1'b1)
      on_o <= on_o + 32'h1;
    if (cool_i === 1'b1)
      cool_on_o <= cool_on_o + 32'h1;
  end
endmodule : slc_relay_model
`default_nettype wire

// file: tb/slc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module slc_top_test;
  import slc_pkg::*;
  logic ref_clk_i = 0, rst_i = 1, cyc = 0, we = 0, pin = 0, o1, o2, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd, on, cool;
  int fails = 0, check_count = 0, n_clk = 0, seed = 32'hccf6;
  slc_top #(.MS_CYCLES(5)) slc_top_inst (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .param_set_pin_i(pin),
    .out1_o(o1), .out2_o(o2));
  slc_relay_model slc_relay_model_inst (.ref_clk_i(ref_clk_i),
    .heat_i(o1), .cool_i(o2), .on_o(on), .cool_on_o(cool));
  // clock and hang limit
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    n_clk++;
    if (n_clk == 100000)
    begin
      fails++;
      stop_test();
    end
  end
  // classic single wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d[15:0]};
    // only the hang limit ends a lost answer
    do
    begin
      @(posedge ref_clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wb
  task automatic rdchk(input string s, input logic [7:0] a, logic [15:0] e);
    wb(1'b0, a, 0);
    `CHK(s, e, rd[15:0])
  endtask : rdchk
  // contact level with symmetric hysteresis round the setpoint
  function automatic logic sig_exp(int pv, int sd, logic prev);
    if (-pv > sd / 2) return 1'b1;
    if (pv > sd / 2) return 1'b0;
    return prev;
  endfunction : sig_exp
  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // main sequence
  initial
  begin
    logic e, e2;
    int pv, p2;
    int c[4] = '{-20, 3, 20, -3};
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdchk("ctrl", ADR_CTRL, 16'h2);
    rdchk("xoff", 8'h10, RST_XOFF);
    rdchk("sd", 8'h0c, RST_SD);
    rdchk("cyc", ADR_PSET_B + 8'h1c, RST_CY);
    rdchk("yhi", 8'h1c, RST_YHI);
    rdchk("hole", 8'hfc, 16'h0);
    wb(1'b1, 8'h18, 1000);
    rdchk("ylo", 8'h18, 16'h0);
    wb(1'b1, ADR_CTRL, 0);
    wb(1'b1, 8'h10, -8);
    e = 1'b0;
    e2 = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      // second half runs the two-contact signaller
      if (i == 12)
        wb(1'b1, ADR_CTRL, 1);
      pv = (i < 4) ? c[i] : $random(seed) % 30;
      wb(1'b1, 8'h04, pv);
      repeat (3) @(posedge ref_clk_i);
      e = sig_exp(pv, 10, e);
      e2 = sig_exp(pv + 8, 10, e2);
      `CHK("out1", e, o1)
      `CHK("out2", (i < 12) ? 1'b0 : e2, o2)
    end
    wb(1'b1, ADR_CTRL, 2);
    wb(1'b1, 8'h04, 0);
    wb(1'b1, ADR_PSET_A + 8'h08, 0);
    wb(1'b1, ADR_PSET_A + 8'h10, 0);
    wb(1'b1, ADR_PSET_A + 8'h18, 10);
    wb(1'b1, ADR_PSET_A + 8'h1c, 10);
    wb(1'b1, 8'h20, 300);
    repeat (4100) @(posedge ref_clk_i);
    rdchk("y0", ADR_STATUS, 16'd300);
    wb(1'b1, 8'h1c, 200);
    repeat (24000) @(posedge ref_clk_i);
    rdchk("clip", ADR_STATUS, 16'd200);
    pv = on;
    repeat (40000) @(posedge ref_clk_i);
    `CHK("duty", 32'd8000, on - pv)
    // three-point, cooling only, then outputs swapped
    wb(1'b1, ADR_CTRL, 3);
    wb(1'b1, 8'h20, -300);
    repeat (6500) @(posedge ref_clk_i);
    rdchk("y3", ADR_STATUS, 16'hfed4);
    for (int k = 0; k < 2; k++)
    begin
      pv = on;
      p2 = cool;
      repeat (5000) @(posedge ref_clk_i);
      `CHK("heat", (k == 0) ? 32'd0 : 32'd1500, on - pv)
      `CHK("cool", (k == 0) ? 32'd1500 : 32'd0, cool - p2)
      wb(1'b1, ADR_CTRL, 7);
    end
    // neutral zone holds y, leaving it recomputes
    wb(1'b1, 8'h24, 50);
    wb(1'b1, 8'h04, -20);
    repeat (1100) @(posedge ref_clk_i);
    rdchk("zone", ADR_STATUS, 16'hfed4);
    wb(1'b1, 8'h24, 0);
    repeat (1100) @(posedge ref_clk_i);
    rdchk("p", ADR_STATUS, 16'hfee8);
    // set select taken from the pin
    wb(1'b1, ADR_CTRL, 23);
    pin <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    wb(1'b0, ADR_STATUS, 0);
    `CHK("set", 1'b1, rd[18])
    stop_test();
  end
endmodule : slc_top_test
`default_nettype wire
